/* File: rtl/vt_tributary_fill_select.sv */
// Transmit fill and receive drop selection for the tributaries of one STS-1
// Function
// RQ1 - Test channel is position 1-4 in group, or channel 1-28 when flat.
// RQ2 - Channel fill covers other three of the group, or other 27 when flat.
// RQ3 - Fills allowed depend on numbering and on async or byte-sync mode.
// RQ4 - Same fill copies the test channel bytes.
// RQ5 - Complement fill inverts the test channel payload.
// RQ6 - Zero fill sends an all-zeros payload.
// RQ7 - DS1 AIS fill sends an unframed all-ones payload.
// RQ8 - AIS fill: all-ones payload async, whole tributary all-ones byte-sync.
// RQ9 - External fill carries the external DS1 bytes.
// RQ10 - Unequipped fill zeros path overhead and payload.
// RQ11 - Drop channel is position 1-4 in group, or 1-28 when flat.
// RQ12 - Drop tie makes the drop channel follow the transmit channel.
// RQ13 - One of seven groups carries the test channel and its fill.
// RQ14 - Group fill same copies the selected group into the other six.
// RQ15 - Group fill path AIS sends all-ones on the other groups.
// RQ16 - Group fill unequipped zeros overhead and payload of other groups.
// RQ17 - Drop group is 1-7, or ties to the transmit group.
// RQ18 - Group numbering addresses position 1-4 within group 1-7.
// RQ19 - Flat number is (position-1)*7 plus group, from 1 to 28.
// RQ20 - Selections take effect only at a frame start.
`timescale 1ns/1ps
module vt_tributary_fill_select (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic NUMBERING_FLAT,
  input wire logic BYTE_SYNC,
  input wire logic [4:0] INS_CHAN,
  input wire logic [2:0] INS_GROUP,
  input wire vt_fill_pkg::chan_fill_t REMAINING_CHANNEL_FILL,
  input wire vt_fill_pkg::grp_fill_t GROUP_FILL,
  input wire logic [4:0] DROP_CHAN,
  input wire logic DROP_CHAN_TIE,
  input wire logic [2:0] DROP_GROUP,
  input wire logic DROP_GROUP_TIE,
  input wire vt_fill_pkg::tx_word_t TX_IN,
  input wire logic TX_IN_VALID,
  output logic TX_IN_READY,
  output vt_fill_pkg::line_word_t TX_OUT,
  output logic TX_OUT_VALID,
  input wire logic TX_OUT_READY,
  input wire vt_fill_pkg::rx_word_t RX_IN,
  input wire logic RX_IN_VALID,
  output logic [7:0] DROP_DATA,
  output logic DROP_VALID,
  output logic DROP_SOF,
  output logic [4:0] TX_FLAT_CHAN,
  output logic [4:0] DROP_FLAT_CHAN,
  output logic TX_CFG_REJECT,
  output logic DROP_CFG_REJECT,
  output logic DROP_LOCKED
);

  // ==========================================================================
  // Numbering helpers
  function automatic logic [4:0] to_flat(input logic [4:0] pos,
                                         input logic [4:0] grp);
    to_flat = 5'((pos - vt_fill_pkg::FIRST_NUM) * vt_fill_pkg::NUM_GROUPS
                 + grp); // [RQ19]
  endfunction : to_flat

  function automatic logic [4:0] slot_group(input logic [4:0] slot);
    slot_group = 5'((slot - vt_fill_pkg::FIRST_NUM) % vt_fill_pkg::NUM_GROUPS
                    + vt_fill_pkg::FIRST_NUM); // [RQ18]
  endfunction : slot_group

  function automatic logic [4:0] slot_pos(input logic [4:0] slot);
    slot_pos = 5'((slot - vt_fill_pkg::FIRST_NUM) / vt_fill_pkg::NUM_GROUPS
                  + vt_fill_pkg::FIRST_NUM); // [RQ18]
  endfunction : slot_pos

  function automatic logic in_range(input logic [4:0] v,
                                    input logic [4:0] top);
    in_range = (v >= vt_fill_pkg::FIRST_NUM) && (v <= top);
  endfunction : in_range

  // Channel fill of one byte from the test or external byte of the same column
  function automatic logic [7:0] chan_byte(input vt_fill_pkg::chan_fill_t f,
                                           input logic bsync,
                                           input vt_fill_pkg::tx_word_t w);
    logic pay;
    pay = (w.kind == vt_fill_pkg::KIND_PAYLOAD);
    unique case (f)
      vt_fill_pkg::FILL_SAME: chan_byte = w.test; // [RQ4]
      vt_fill_pkg::FILL_INV: chan_byte = pay ? ~w.test : w.test; // [RQ5]
      vt_fill_pkg::FILL_ZERO: begin
        chan_byte = pay ? vt_fill_pkg::BYTE_ZERO : w.test; // [RQ6]
      end
      vt_fill_pkg::FILL_DS1_AIS: begin
        chan_byte = pay ? vt_fill_pkg::BYTE_ONES : w.test; // [RQ7]
      end
      vt_fill_pkg::FILL_AIS: begin
        chan_byte = (pay || bsync) ? vt_fill_pkg::BYTE_ONES : w.test; // [RQ8]
      end
      vt_fill_pkg::FILL_EXT: chan_byte = pay ? w.ext : w.test; // [RQ9]
      vt_fill_pkg::FILL_UNEQ: begin
        chan_byte = (w.kind == vt_fill_pkg::KIND_PTR) ? w.test
                    : vt_fill_pkg::BYTE_ZERO; // [RQ10]
      end
      default: chan_byte = w.test;
    endcase
  endfunction : chan_byte

  // ==========================================================================
  // Transmit selection legality
  vt_fill_pkg::sel_cfg_t cfg_ff;
  vt_fill_pkg::sel_cfg_t nxt_cfg;
  vt_fill_pkg::sel_cfg_t eff_cfg;
  logic cfg_legal;
  logic fill_legal;
  logic tx_acc;
  logic tx_take;
  logic fifo_in_ready;
  logic tx_cfg_reject_ff;

  assign nxt_cfg = '{flat: NUMBERING_FLAT, bsync: BYTE_SYNC,
                     ins_chan: INS_CHAN, ins_group: INS_GROUP,
                     remaining_channel_fill: REMAINING_CHANNEL_FILL,
                     grp_fill: GROUP_FILL};

  always_comb begin
    if (NUMBERING_FLAT) begin
      fill_legal = (REMAINING_CHANNEL_FILL == vt_fill_pkg::FILL_SAME) ||
                   (REMAINING_CHANNEL_FILL == vt_fill_pkg::FILL_AIS) ||
                   (REMAINING_CHANNEL_FILL == vt_fill_pkg::FILL_UNEQ); // [RQ3]
      cfg_legal = fill_legal &&
                  in_range(INS_CHAN, vt_fill_pkg::NUM_CHAN); // [RQ1]
    end else begin
      fill_legal = (REMAINING_CHANNEL_FILL == vt_fill_pkg::FILL_SAME) ||
                   (REMAINING_CHANNEL_FILL == vt_fill_pkg::FILL_INV) ||
                   (REMAINING_CHANNEL_FILL == vt_fill_pkg::FILL_ZERO) ||
                   (!BYTE_SYNC &&
                    ((REMAINING_CHANNEL_FILL == vt_fill_pkg::FILL_DS1_AIS) ||
                     (REMAINING_CHANNEL_FILL == vt_fill_pkg::FILL_EXT)));
                   // [RQ3]
      cfg_legal = fill_legal &&
                  in_range(INS_CHAN, vt_fill_pkg::NUM_POS) && // [RQ1]
                  in_range({2'h0, INS_GROUP}, vt_fill_pkg::NUM_GROUPS) &&
                  (GROUP_FILL != 2'h3); // [RQ13]
    end
  end

  // The frame's first word already uses the new selection, so no frame mixes
  assign tx_acc = CE && TX_IN_VALID && fifo_in_ready;
  assign tx_take = tx_acc && TX_IN.sof && cfg_legal; // [RQ20]
  assign eff_cfg = tx_take ? nxt_cfg : cfg_ff;
  assign TX_IN_READY = fifo_in_ready;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_ff <= '{flat: 1'b0, bsync: 1'b0,
                  ins_chan: vt_fill_pkg::RESET_CHAN,
                  ins_group: vt_fill_pkg::RESET_GROUP,
                  remaining_channel_fill: vt_fill_pkg::FILL_SAME,
                  grp_fill: vt_fill_pkg::GFILL_SAME};
    end else if (tx_take) begin
      cfg_ff <= nxt_cfg; // [RQ20]
    end
  end

  // Illegal settings are held off, not half applied, until corrected
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_cfg_reject_ff <= 1'b0;
    end else if (tx_acc && TX_IN.sof) begin
      tx_cfg_reject_ff <= !cfg_legal; // [RQ3]
    end
  end

  assign TX_CFG_REJECT = tx_cfg_reject_ff;

  // ==========================================================================
  // Transmit byte selection
  logic [4:0] ins_flat;
  logic [4:0] ins_grp5;
  logic [4:0] w_grp;
  logic [4:0] w_pos;
  logic [7:0] grp_byte;
  logic [7:0] tx_byte;
  vt_fill_pkg::line_word_t fifo_in;

  assign ins_grp5 = {2'h0, eff_cfg.ins_group};
  assign ins_flat = eff_cfg.flat ? eff_cfg.ins_chan
                    : to_flat(eff_cfg.ins_chan, ins_grp5); // [RQ19]
  assign w_grp = slot_group(TX_IN.slot);
  assign w_pos = slot_pos(TX_IN.slot);

  // Selected group content as seen at this column's position
  assign grp_byte = (w_pos == eff_cfg.ins_chan) ? TX_IN.test
                    : chan_byte(eff_cfg.remaining_channel_fill, eff_cfg.bsync,
                                TX_IN); // [RQ2]

  always_comb begin
    if (eff_cfg.flat) begin
      tx_byte = (TX_IN.slot == ins_flat) ? TX_IN.test // [RQ1]
                : chan_byte(eff_cfg.remaining_channel_fill, eff_cfg.bsync,
                            TX_IN); // [RQ2]
    end else if (w_grp == ins_grp5) begin
      tx_byte = grp_byte; // [RQ13]
    end else begin
      unique case (eff_cfg.grp_fill)
        vt_fill_pkg::GFILL_SAME: tx_byte = grp_byte; // [RQ14]
        vt_fill_pkg::GFILL_PAIS: tx_byte = vt_fill_pkg::BYTE_ONES; // [RQ15]
        vt_fill_pkg::GFILL_UNEQ: begin
          tx_byte = (TX_IN.kind == vt_fill_pkg::KIND_PTR) ? TX_IN.test
                    : vt_fill_pkg::BYTE_ZERO; // [RQ16]
        end
        default: tx_byte = grp_byte;
      endcase
    end
  end

  assign fifo_in = '{sof: TX_IN.sof, kind: TX_IN.kind, slot: TX_IN.slot,
                     data: tx_byte};
  assign TX_FLAT_CHAN = cfg_ff.flat ? cfg_ff.ins_chan
                        : to_flat(cfg_ff.ins_chan, {2'h0, cfg_ff.ins_group});

  vt_word_fifo #(
    .WIDTH($bits(vt_fill_pkg::line_word_t)),
    .DEPTH(vt_fill_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .ce(CE),
    .in_valid(TX_IN_VALID),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(TX_OUT_VALID),
    .out_ready(TX_OUT_READY),
    .out_data(TX_OUT)
  );

  // ==========================================================================
  // Receive drop selection
  typedef enum logic {RX_HUNT, RX_LOCK} rx_state_t;
  rx_state_t rx_state_ff;
  logic rx_acc;
  logic rx_sof;
  logic [4:0] drop_pos;
  logic [4:0] drop_grp;
  logic [4:0] nxt_drop_flat;
  logic drop_legal;
  logic [4:0] drop_flat_ff;
  logic drop_reject_ff;
  logic [7:0] drop_data_ff;
  logic drop_valid_ff;
  logic drop_sof_ff;
  logic sof_pend_ff;
  logic rx_hit;

  assign rx_acc = CE && RX_IN_VALID;
  assign rx_sof = rx_acc && RX_IN.sof;
  assign drop_pos = DROP_CHAN_TIE ? cfg_ff.ins_chan : DROP_CHAN; // [RQ12]
  assign drop_grp = DROP_GROUP_TIE ? {2'h0, cfg_ff.ins_group}
                    : {2'h0, DROP_GROUP}; // [RQ17]

  always_comb begin
    if (cfg_ff.flat) begin
      nxt_drop_flat = drop_pos; // [RQ11]
      drop_legal = in_range(drop_pos, vt_fill_pkg::NUM_CHAN);
    end else begin
      nxt_drop_flat = to_flat(drop_pos, drop_grp); // [RQ11]
      drop_legal = in_range(drop_pos, vt_fill_pkg::NUM_POS) &&
                   in_range(drop_grp, vt_fill_pkg::NUM_GROUPS);
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_state_ff <= RX_HUNT;
    end else if (rx_sof) begin
      rx_state_ff <= RX_LOCK;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      drop_flat_ff <= vt_fill_pkg::RESET_CHAN;
      drop_reject_ff <= 1'b0;
    end else if (rx_sof) begin
      drop_reject_ff <= !drop_legal;
      if (drop_legal) begin
        drop_flat_ff <= nxt_drop_flat; // [RQ20]
      end
    end
  end

  // The frame-start word itself may be the dropped column
  assign rx_hit = rx_acc && (rx_sof || (rx_state_ff == RX_LOCK)) &&
                  (RX_IN.slot == ((rx_sof && drop_legal) ? nxt_drop_flat
                                  : drop_flat_ff));

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sof_pend_ff <= 1'b0;
    end else if (CE) begin
      if (rx_hit) begin
        sof_pend_ff <= 1'b0;
      end else if (rx_sof) begin
        sof_pend_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      drop_data_ff <= '0;
      drop_valid_ff <= 1'b0;
      drop_sof_ff <= 1'b0;
    end else if (CE) begin
      drop_valid_ff <= rx_hit; // [RQ11]
      drop_sof_ff <= rx_hit && (sof_pend_ff || rx_sof);
      if (rx_hit) begin
        drop_data_ff <= RX_IN.data;
      end
    end
  end

  assign DROP_DATA = drop_data_ff;
  assign DROP_VALID = drop_valid_ff;
  assign DROP_SOF = drop_sof_ff;
  assign DROP_FLAT_CHAN = drop_flat_ff;
  assign DROP_CFG_REJECT = drop_reject_ff;
  assign DROP_LOCKED = (rx_state_ff == RX_LOCK);

  // ==========================================================================
  // Checks
  logic other_chan;
  assign other_chan = (TX_IN.slot != ins_flat);

  sequence s_rx_hit;
    rx_acc && (rx_state_ff == RX_LOCK) && !RX_IN.sof &&
    (RX_IN.slot == drop_flat_ff);
  endsequence

  sequence s_drop_out;
    DROP_VALID && (DROP_DATA == $past(RX_IN.data));
  endsequence

  property p_flat_test;
    @(posedge REF_CLK) disable iff (!RESETN)
    tx_acc && eff_cfg.flat && !other_chan |-> fifo_in.data == TX_IN.test;
  endproperty
  a_flat_test: assert property (p_flat_test) // [RQ1]
    else $error("test channel byte not passed");

  property p_zero_fill;
    @(posedge REF_CLK) disable iff (!RESETN)
    tx_acc && !eff_cfg.flat && (w_grp == ins_grp5) &&
    (w_pos != eff_cfg.ins_chan) &&
    (eff_cfg.remaining_channel_fill == vt_fill_pkg::FILL_ZERO) &&
    (TX_IN.kind == vt_fill_pkg::KIND_PAYLOAD) |-> fifo_in.data == 8'h00;
  endproperty
  a_zero_fill: assert property (p_zero_fill) // [RQ6]
    else $error("zero fill payload not zero");

  property p_uneq_flat;
    @(posedge REF_CLK) disable iff (!RESETN)
    tx_acc && eff_cfg.flat && other_chan &&
    (eff_cfg.remaining_channel_fill == vt_fill_pkg::FILL_UNEQ) &&
    (TX_IN.kind != vt_fill_pkg::KIND_PTR) |-> fifo_in.data == 8'h00;
  endproperty
  a_uneq_flat: assert property (p_uneq_flat) // [RQ10]
    else $error("unequipped channel not zero");

  property p_grp_pais;
    @(posedge REF_CLK) disable iff (!RESETN)
    tx_acc && !eff_cfg.flat && (w_grp != ins_grp5) &&
    (eff_cfg.grp_fill == vt_fill_pkg::GFILL_PAIS) |-> fifo_in.data == 8'hff;
  endproperty
  a_grp_pais: assert property (p_grp_pais) // [RQ15]
    else $error("path AIS group not all ones");

  property p_cfg_frame;
    @(posedge REF_CLK) disable iff (!RESETN)
    $changed(cfg_ff) |-> $past(tx_acc && TX_IN.sof);
  endproperty
  a_cfg_frame: assert property (p_cfg_frame) // [RQ20]
    else $error("selection changed mid frame");

  property p_drop;
    @(posedge REF_CLK) disable iff (!RESETN)
    s_rx_hit |=> s_drop_out;
  endproperty
  a_drop: assert property (p_drop) // [RQ11]
    else $error("selected channel not dropped");

  property p_drop_only_sel;
    @(posedge REF_CLK) disable iff (!RESETN)
    $rose(DROP_VALID) && !$past(RX_IN.sof) |->
    $past(RX_IN.slot) == $past(drop_flat_ff);
  endproperty
  a_drop_only_sel: assert property (p_drop_only_sel) // [RQ17]
    else $error("wrong channel dropped");

  property p_flat_range;
    @(posedge REF_CLK) disable iff (!RESETN)
    TX_FLAT_CHAN >= 5'h01 && TX_FLAT_CHAN <= 5'h1c &&
    DROP_FLAT_CHAN >= 5'h01 && DROP_FLAT_CHAN <= 5'h1c;
  endproperty
  a_flat_range: assert property (p_flat_range) // [RQ19]
    else $error("flat channel number out of range");

  property p_hold;
    @(posedge REF_CLK) disable iff (!RESETN)
    TX_OUT_VALID && !TX_OUT_READY |=> TX_OUT_VALID && $stable(TX_OUT);
  endproperty
  a_hold: assert property (p_hold) // output word held while TX_OUT_READY is low
    else $error("output word dropped under stall");

endmodule : vt_tributary_fill_select

/* File: rtl/vt_fill_pkg.sv */
// Shared constants, enumerations and carriers for tributary fill selection
package vt_fill_pkg;

  // ==========================================================================
  // Tributary geometry
  localparam logic [4:0] NUM_CHAN = 5'h1c;
  localparam logic [4:0] NUM_GROUPS = 5'h07;
  localparam logic [4:0] NUM_POS = 5'h04;
  localparam logic [4:0] FIRST_NUM = 5'h01;
  localparam logic [4:0] RESET_CHAN = 5'h01;
  localparam logic [2:0] RESET_GROUP = 3'h1;

  // ==========================================================================
  // Byte patterns
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ==========================================================================
  // Buffering
  localparam int FIFO_DEPTH = 16;

  // ==========================================================================
  // Modes
  typedef enum logic [2:0] {
    FILL_SAME,
    FILL_INV,
    FILL_ZERO,
    FILL_DS1_AIS,
    FILL_AIS,
    FILL_EXT,
    FILL_UNEQ
  } chan_fill_t;

  typedef enum logic [1:0] {
    GFILL_SAME,
    GFILL_PAIS,
    GFILL_UNEQ
  } grp_fill_t;

  typedef enum logic [1:0] {
    KIND_PTR,
    KIND_POH,
    KIND_PAYLOAD
  } byte_kind_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic flat;
    logic bsync;
    logic [4:0] ins_chan;
    logic [2:0] ins_group;
    chan_fill_t remaining_channel_fill;
    grp_fill_t grp_fill;
  } sel_cfg_t;

  typedef struct packed {
    logic sof;
    byte_kind_t kind;
    logic [4:0] slot;
    logic [7:0] test;
    logic [7:0] ext;
  } tx_word_t;

  typedef struct packed {
    logic sof;
    byte_kind_t kind;
    logic [4:0] slot;
    logic [7:0] data;
  } line_word_t;

  typedef struct packed {
    logic sof;
    logic [4:0] slot;
    logic [7:0] data;
  } rx_word_t;

endpackage : vt_fill_pkg

/* File: rtl/vt_word_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module vt_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != FULL_CNT);
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  // ==========================================================================
  // Storage
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_ff[i] <= '0;
      end else if (push && (wr_ptr_ff == AW'(i))) begin
        mem_ff[i] <= in_data;
      end
    end
  end

  // ==========================================================================
  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
    end else if (push) begin
      wr_ptr_ff <= (wr_ptr_ff == LAST_IDX) ? '0 : wr_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_ff <= '0;
    end else if (pop) begin
      rd_ptr_ff <= (rd_ptr_ff == LAST_IDX) ? '0 : rd_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else if (push != pop) begin
      count_ff <= push ? count_ff + 1'b1 : count_ff - 1'b1;
    end
  end

endmodule : vt_word_fifo

/* File: bench/vt_line_partner.sv */
// Far-side line equipment model: sinks transmit words, sources receive words
`timescale 1ns/1ps
module vt_line_partner (
  input wire logic clk,
  input wire logic stall,
  input wire vt_fill_pkg::line_word_t tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  output vt_fill_pkg::rx_word_t rx_word,
  output logic rx_valid
);
  // ==========================================
  // Transmit sink and receive source
  vt_fill_pkg::line_word_t rcv[$];

  initial begin
    rx_word = '0;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end

  // Ready moves just after an edge, so stalls never race the sampling edge
  always @(posedge clk) begin
    if (tx_valid && tx_ready) rcv.push_back(tx_word);
    tx_ready <= !stall;
  end

  task automatic send(input logic [4:0] slot, input logic [7:0] d,
                      input logic s);
    @(negedge clk);
    rx_word = '{sof: s, slot: slot, data: d};
    rx_valid = 1'b1;
    @(posedge clk);
  endtask : send

  // Released lines show the inverse byte, never a stale copy
  task automatic idle();
    @(negedge clk);
    rx_valid = 1'b0;
    rx_word.data = ~rx_word.data;
  endtask : idle
endmodule : vt_line_partner

/* File: bench/vt_tributary_fill_select_tb_top.sv */
// Self-checking bench for tributary fill and drop selection
`timescale 1ns/1ps
module vt_tributary_fill_select_tb_top;
  // ==========================================
  // Signals
  logic ref_clk, resetn, stall, tx_in_valid, tx_in_ready, tx_out_valid;
  logic tx_out_ready, rx_in_valid, drop_valid, drop_sof, tx_rej, drop_rej;
  logic drop_locked, drop_chan_tie, drop_grp_tie;
  logic [4:0] drop_chan, tx_flat, drop_flat;
  logic [2:0] drop_grp;
  logic [7:0] drop_data;
  vt_fill_pkg::sel_cfg_t cfg, app;
  vt_fill_pkg::tx_word_t tx_in;
  vt_fill_pkg::line_word_t tx_out;
  vt_fill_pkg::rx_word_t rx_in;
  logic [7:0] exp_q[$];
  logic [8:0] drop_q[$];
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  vt_tributary_fill_select uut (
    .REF_CLK(ref_clk), .RESETN(resetn), .CE(1'b1),
    .NUMBERING_FLAT(cfg.flat), .BYTE_SYNC(cfg.bsync),
    .INS_CHAN(cfg.ins_chan), .INS_GROUP(cfg.ins_group),
    .REMAINING_CHANNEL_FILL(cfg.remaining_channel_fill),
    .GROUP_FILL(cfg.grp_fill), .DROP_CHAN(drop_chan),
    .DROP_CHAN_TIE(drop_chan_tie), .DROP_GROUP(drop_grp),
    .DROP_GROUP_TIE(drop_grp_tie), .TX_IN(tx_in),
    .TX_IN_VALID(tx_in_valid), .TX_IN_READY(tx_in_ready),
    .TX_OUT(tx_out), .TX_OUT_VALID(tx_out_valid),
    .TX_OUT_READY(tx_out_ready), .RX_IN(rx_in), .RX_IN_VALID(rx_in_valid),
    .DROP_DATA(drop_data), .DROP_VALID(drop_valid), .DROP_SOF(drop_sof),
    .TX_FLAT_CHAN(tx_flat), .DROP_FLAT_CHAN(drop_flat),
    .TX_CFG_REJECT(tx_rej), .DROP_CFG_REJECT(drop_rej),
    .DROP_LOCKED(drop_locked)
  );

  vt_line_partner far (
    .clk(ref_clk), .stall(stall), .tx_word(tx_out),
    .tx_valid(tx_out_valid), .tx_ready(tx_out_ready),
    .rx_word(rx_in), .rx_valid(rx_in_valid)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (drop_valid) drop_q.push_back({drop_sof, drop_data});
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end

  // ==========================================
  // Tasks
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [8:0] seen,
                       input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic vt_fill_pkg::sel_cfg_t mk(input logic f, b,
      input logic [4:0] ch, input logic [2:0] g, input logic [2:0] cf,
      input logic [1:0] gf);
    return '{f, b, ch, g, vt_fill_pkg::chan_fill_t'(cf),
             vt_fill_pkg::grp_fill_t'(gf)};
  endfunction : mk

  function automatic logic [7:0] exp_byte(input vt_fill_pkg::tx_word_t w);
    logic [4:0] g;
    logic [4:0] ps;
    logic pay;
    logic ptr;
    g = (w.slot - 5'h01) % 5'h07 + 5'h01;
    ps = (w.slot - 5'h01) / 5'h07 + 5'h01;
    pay = w.kind == vt_fill_pkg::KIND_PAYLOAD;
    ptr = w.kind == vt_fill_pkg::KIND_PTR;
    if (!app.flat && g != {2'h0, app.ins_group}) begin
      if (app.grp_fill == vt_fill_pkg::GFILL_PAIS) return 8'hff;
      if (app.grp_fill == vt_fill_pkg::GFILL_UNEQ) return ptr ? w.test : 8'h00;
    end
    if ((app.flat ? w.slot : ps) == app.ins_chan) return w.test;
    case (app.remaining_channel_fill)
      vt_fill_pkg::FILL_INV: return pay ? ~w.test : w.test;
      vt_fill_pkg::FILL_ZERO: return pay ? 8'h00 : w.test;
      vt_fill_pkg::FILL_DS1_AIS: return pay ? 8'hff : w.test;
      vt_fill_pkg::FILL_AIS: return (pay || app.bsync) ? 8'hff : w.test;
      vt_fill_pkg::FILL_EXT: return pay ? w.ext : w.test;
      vt_fill_pkg::FILL_UNEQ: return ptr ? w.test : 8'h00;
      default: return w.test;
    endcase
  endfunction : exp_byte

  task automatic push(input vt_fill_pkg::tx_word_t w,
                      input vt_fill_pkg::sel_cfg_t c);
    @(negedge ref_clk);
    tx_in = w;
    cfg = c;
    tx_in_valid = 1'b1;
    while (!tx_in_ready) @(negedge ref_clk);
    @(posedge ref_clk);
  endtask : push

  // Selection pins may move to nxt after the frame start word
  task automatic tx_frame(input logic [7:0] seed, input logic lg,
                          input vt_fill_pkg::sel_cfg_t nxt);
    vt_fill_pkg::tx_word_t w;
    for (int s = 1; s <= 28; s++) begin
      w = '{s == 1, vt_fill_pkg::byte_kind_t'(s % 3), 5'(s), seed + 8'(s),
            ~seed - 8'(s)};
      if (s == 1 && lg) app = cfg;
      exp_q.push_back(exp_byte(w));
      push(w, (s == 1) ? cfg : nxt);
    end
    @(negedge ref_clk);
    tx_in_valid = 1'b0;
  endtask : tx_frame

  task automatic drain();
    vt_fill_pkg::line_word_t r;
    int k = 0;
    repeat (80) if (far.rcv.size() < exp_q.size()) @(posedge ref_clk);
    check("tx words", 9'(far.rcv.size()), 9'(exp_q.size()));
    while (exp_q.size() > 0 && far.rcv.size() > 0) begin
      r = far.rcv.pop_front();
      k++;
      check("tx slot", {3'h0, r.sof, r.slot}, {3'h0, k == 1, 5'(k)});
      check("tx byte", {1'b0, r.data}, {1'b0, exp_q.pop_front()});
    end
    exp_q.delete();
    far.rcv.delete();
    @(negedge ref_clk);
  endtask : drain

  task automatic run(input logic f, b, input logic [4:0] ch,
      input logic [2:0] g, input logic [2:0] cf, input logic [1:0] gf,
      input logic lg);
    cfg = mk(f, b, ch, g, cf, gf);
    tx_frame(8'h40 + {3'h0, ch}, lg, cfg);
    drain();
    check("tx flat", {4'h0, tx_flat}, {4'h0, app.flat ? app.ins_chan :
          (app.ins_chan - 5'h01) * 5'h07 + {2'h0, app.ins_group}});
  endtask : run

  task automatic rx_frame(input logic [4:0] hit, input logic [7:0] base);
    drop_q.delete();
    for (int s = 1; s <= 28; s++) far.send(5'(s), base + 8'(s), s == 1);
    far.idle();
    repeat (2) @(negedge ref_clk);
    check("drop hits", 9'(drop_q.size()), 9'h001);
    check("drop byte", (drop_q.size() > 0) ? drop_q[0] : 9'h000,
          {1'b1, base + {3'h0, hit}});
    check("drop chan", {4'h0, drop_flat}, {4'h0, hit});
    check("drop rej", {8'h0, drop_rej}, 9'h000);
  endtask : rx_frame

  // ==========================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    stall = 1'b0;
    tx_in = '0;
    tx_in_valid = 1'b0;
    {drop_chan_tie, drop_grp_tie, drop_chan, drop_grp} = '0;
    cfg = mk(1'b0, 1'b0, vt_fill_pkg::RESET_CHAN, vt_fill_pkg::RESET_GROUP,
             3'h0, 2'h0);
    app = cfg;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    check("in ready", {8'h0, tx_in_ready}, 9'h001);
    check("out valid", {8'h0, tx_out_valid}, 9'h000);
    check("locked", {8'h0, drop_locked}, 9'h000);
    run(1'b0, 1'b0, 5'h02, 3'h3, 3'h0, 2'h1, 1'b1);
    run(1'b0, 1'b0, 5'h04, 3'h7, 3'h2, 2'h0, 1'b1);
    run(1'b0, 1'b0, 5'h01, 3'h1, 3'h3, 2'h1, 1'b1);
    run(1'b0, 1'b0, 5'h03, 3'h5, 3'h5, 2'h0, 1'b1);
    run(1'b0, 1'b1, 5'h02, 3'h3, 3'h1, 2'h0, 1'b1);
    run(1'b1, 1'b0, 5'h1c, 3'h1, 3'h4, 2'h0, 1'b1);
    run(1'b1, 1'b1, 5'h0a, 3'h1, 3'h4, 2'h0, 1'b1);
    run(1'b1, 1'b0, 5'h01, 3'h1, 3'h6, 2'h0, 1'b1);
    run(1'b0, 1'b0, 5'h02, 3'h3, 3'h1, 2'h2, 1'b1);
    drop_chan = 5'h04;
    drop_grp = 3'h1;
    rx_frame(5'h16, 8'h20);
    {drop_chan_tie, drop_grp_tie} = 2'b11;
    rx_frame(5'h0a, 8'h60);
    check("locked", {8'h0, drop_locked}, 9'h001);
    run(1'b1, 1'b0, 5'h05, 3'h1, 3'h1, 2'h0, 1'b0);
    check("reject", {8'h0, tx_rej}, 9'h001);
    cfg = mk(1'b0, 1'b0, 5'h01, 3'h2, 3'h2, 2'h1);
    tx_frame(8'h11, 1'b1, mk(1'b0, 1'b0, 5'h03, 3'h4, 3'h0, 2'h0));
    drain();
    check("reject", {8'h0, tx_rej}, 9'h000);
    stall = 1'b1;
    fork
      tx_frame(8'h77, 1'b1, cfg);
      begin
        repeat (30) @(negedge ref_clk);
        check("full ready", {8'h0, tx_in_ready}, 9'h000);
        stall = 1'b0;
      end
    join
    drain();
    close_out();
  end
endmodule : vt_tributary_fill_select_tb_top
